// ### hdl/tisq_pkg.sv
package tisq_pkg;
	// sizes
	localparam int NUM_SRC   = 16;      // interrupt sources, natural order 0 = highest
	localparam int NUM_EXT   = 5;       // external request pins, sources 0..4
	localparam int NUM_POL   = 3;       // pins with a selectable edge polarity
	localparam int CTX_DEPTH = 8;       // context stack entries
	localparam int PC_W      = 24;      // program counter width
	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_FLAG    = 8'h08;
	localparam logic [7:0] OFF_ENABLE  = 8'h0c;
	localparam logic [7:0] OFF_PRIO_LO = 8'h10;
	localparam logic [7:0] OFF_PRIO_HI = 8'h14;
	localparam logic [7:0] OFF_TRAP    = 8'h18;
	localparam logic [7:0] OFF_STKLIM  = 8'h1c;
	localparam logic [7:0] OFF_RSTCTRL = 8'h20;
	localparam logic [7:0] OFF_VECTOR  = 8'h24;
	// control register fields
	localparam int CTRL_ALT_BIT = 15;   // alt_table_select
	localparam int CTRL_OVA_BIT = 10;   // accumulator a overflow trap enable
	localparam int CTRL_OVB_BIT = 9;    // accumulator b overflow trap enable
	localparam int CTRL_COV_BIT = 8;    // catastrophic overflow trap enable
	localparam int CTRL_EP_LSB  = 0;    // ext0_edge_polarity and the next two
	localparam int CONFLICT_BIT = 15;   // conflict_reset_flag in reset_control_reg
	// trap levels as index above level 8
	localparam int TRAP_MATH  = 3;      // level 11, soft
	localparam int TRAP_ADDR  = 4;      // level 12, hard
	localparam int TRAP_STACK = 5;      // level 13, hard
	localparam int TRAP_OSC   = 6;      // level 14, hard
	localparam logic [15:0] STACK_FLOOR  = 16'h0800;
	localparam logic [2:0]  PRIO_RESET   = 3'h4;
	localparam logic [15:0] STKLIM_RESET = 16'hffff;
	localparam logic [5:0]  IRQ_VEC_BASE = 6'h08;  // irq vectors follow the eight trap vectors

	// per-cycle control from the core pipeline
	typedef struct packed {
		logic            cycleStart;    // first clock of an instruction cycle
		logic            takeAck;       // core accepts the offered vector
		logic [PC_W-1:0] pc;            // pc to stack on takeAck
		logic            returnOp;      // return_from_irq_op executed
		logic            lowPower;      // core sleeping or idle
	} tisq_ctl_type;

	// trap conditions reported by the core, one-cycle pulses
	typedef struct packed {
		logic        divZero;
		logic [1:0]  accOv31;           // a, b overflow out of bit 31
		logic        guardUsed;
		logic [1:0]  accOv39;           // a, b overflow out of bit 39
		logic        satOff;            // all saturation disabled
		logic        shiftTooBig;
		logic        misaligned;
		logic        unimplData;
		logic        unimplProg;
		logic        vectorFetch;
		logic        macXinY;           // x access landed in y space
		logic        macYinX;           // y access landed in x space
		logic        branchUnimpl;
		logic        pcUnimpl;
		logic        spLoad;
		logic [15:0] spValue;
		logic        oscFail;
	} tisq_trapsrc_type;

	// everything handed back to the core
	typedef struct packed {
		logic            irqReq;
		logic [PC_W-1:0] vectorAddr;
		logic [3:0]      reqLevel;
		logic [3:0]      cpuPriorityLevel;
		logic            trapPriorityBit;
		logic            haltExec;
		logic            resetOut;
		logic            wake;
		logic            divAbort;
		logic [PC_W-1:0] restoredPc;
		logic            restoreValid;
	} tisq_out_type;

	// whole state of the sequencer
	typedef struct packed {
		logic                              waitReq;
		logic [31:0]                       readData;
		logic [15:0]                       ctrl;
		logic [NUM_SRC-1:0]                flags;
		logic [NUM_SRC-1:0]                enables;
		logic [NUM_SRC-1:0][2:0]           prio;
		logic [NUM_SRC-1:0]                eventHold;
		logic [7:0]                        trapPend;
		logic [3:0]                        hardBusy;
		logic [15:0]                       stackLimit;
		logic                              conflict;
		logic [NUM_EXT-1:0]                extSync1;
		logic [NUM_EXT-1:0]                extSync2;
		logic [NUM_EXT-1:0]                extPrev;
		logic [CTX_DEPTH-1:0][PC_W-1:0]    ctxPc;
		logic [CTX_DEPTH-1:0][3:0]         ctxLvl;
		logic [CTX_DEPTH-1:0][3:0]         ctxSvc;
		logic [3:0]                        ctxCnt;
		tisq_out_type                      out;
	} tisq_state_type;
endpackage

// ### hdl/tisq_core.sv
`timescale 1ns/1ps
module tisq_core
	import tisq_pkg::*;
#(
	parameter logic [PC_W-1:0] VECTOR_BASE      = 24'h000004,  // primary_vector_table base
	parameter logic [PC_W-1:0] ALT_TABLE_OFFSET = 24'h000080   // alternate_vector_table distance
)
(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset_n,
	// avalon-mm register slave
	input  wire logic [7:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic      [31:0]        avs_readdata,
	output logic                    avs_waitrequest,
	// core pipeline side
	input  wire tisq_ctl_type       coreCtl,
	input  wire tisq_trapsrc_type   trapSrc,
	input  wire logic [NUM_SRC-1:0] periphEvents,
	input  wire logic [NUM_EXT-1:0] extIrqPins,
	output tisq_out_type            coreOut
);

	tisq_state_type     s;          // registered state
	tisq_state_type     next_s;     // next state
	logic               busRd;      // first cycle of a read
	logic               busWr;      // write completes this edge
	logic [31:0]        wmask;      // byte-enable mask
	logic [NUM_EXT-1:0] extEdge;    // qualified external edges
	logic [NUM_SRC-1:0] evtVec;     // this cycle's interrupt events
	logic [NUM_SRC-1:0] pendIrq;    // enabled pending requests
	logic [7:0]         newTraps;   // trap conditions this cycle
	logic [3:0]         hardAll;    // hard traps busy or arriving
	logic               conflict;   // hard trap conflict now
	logic               anyTrap;
	logic [2:0]         trapIdx;
	logic               anyIrq;
	logic [2:0]         bestPrio;
	logic [4:0]         bestSrc;
	logic [3:0]         candLvl;
	logic [5:0]         vecNum;
	logic               qualify;    // candidate beats cpu level
	logic [2:0]         topIdx;     // top of context stack

	// reset image, shared by reset_n and the conflict reset
	function automatic tisq_state_type reset_state();
		tisq_state_type r;
		r = '0;
		r.waitReq = 1'b1;
		r.stackLimit = STKLIM_RESET;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			r.prio[i] = PRIO_RESET;
		end
		return r;
	endfunction

	// byte-lane merge of a bus write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		return (old & ~m) | (wd & m);
	endfunction

	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign topIdx = 3'(s.ctxCnt - 4'h1);

	// next-state logic
	always_comb
	begin
		next_s = s;
		next_s.out.resetOut = 1'b0;
		next_s.out.wake = 1'b0;
		next_s.out.divAbort = 1'b0;
		next_s.out.restoreValid = 1'b0;

		// bus: one wait cycle, read data stands at the releasing edge
		busRd = avs_read && s.waitReq;
		busWr = avs_write && !s.waitReq;
		next_s.waitReq = !((avs_read || avs_write) && s.waitReq);
		if (busRd)
		begin
			case (avs_address)
				OFF_CTRL:    next_s.readData = {16'h0, s.ctrl};
				OFF_STATUS:  next_s.readData = {28'h0, s.out.cpuPriorityLevel};
				OFF_FLAG:    next_s.readData = {16'h0, s.flags};
				OFF_ENABLE:  next_s.readData = {16'h0, s.enables};
				OFF_PRIO_LO:
				begin
					next_s.readData = 32'h0;
					for (int i = 0; i < 8; i++)
					begin
						next_s.readData[i*4 +: 3] = s.prio[i];
					end
				end
				OFF_PRIO_HI:
				begin
					next_s.readData = 32'h0;
					for (int i = 0; i < 8; i++)
					begin
						next_s.readData[i*4 +: 3] = s.prio[i+8];
					end
				end
				OFF_TRAP:    next_s.readData = {20'h0, s.hardBusy, s.trapPend};
				OFF_STKLIM:  next_s.readData = {16'h0, s.stackLimit};
				OFF_RSTCTRL: next_s.readData = {16'h0, s.conflict, 15'h0};
				OFF_VECTOR:  next_s.readData = {8'h0, s.out.vectorAddr};
				default:     next_s.readData = 32'h0;                              // unmapped reads zero
			endcase
		end
		if (busWr)
		begin
			case (avs_address)
				OFF_CTRL:    next_s.ctrl = 16'(merge({16'h0, s.ctrl}, avs_writedata, wmask));
				OFF_STATUS:
				begin
					// the trap bit is hardware owned; software only moves levels 0-7 outside traps
					if (avs_byteenable[0] && !s.out.trapPriorityBit)
					begin
						next_s.out.cpuPriorityLevel = {1'b0, avs_writedata[2:0]};
					end
				end
				OFF_FLAG:    next_s.flags = s.flags & ~(avs_writedata[15:0] & wmask[15:0]);
				OFF_ENABLE:  next_s.enables = 16'(merge({16'h0, s.enables}, avs_writedata, wmask));
				OFF_PRIO_LO:
				begin
					for (int i = 0; i < 8; i++)
					begin
						if (wmask[i*4])
						begin
							next_s.prio[i] = avs_writedata[i*4 +: 3];
						end
					end
				end
				OFF_PRIO_HI:
				begin
					for (int i = 0; i < 8; i++)
					begin
						if (wmask[i*4])
						begin
							next_s.prio[i+8] = avs_writedata[i*4 +: 3];
						end
					end
				end
				// soft traps may be dismissed by software; hard ones only by being taken
				OFF_TRAP:    next_s.trapPend = s.trapPend & ~(avs_writedata[7:0] & wmask[7:0] & 8'h0f);
				OFF_STKLIM:  next_s.stackLimit = 16'(merge({16'h0, s.stackLimit}, avs_writedata, wmask));
				OFF_RSTCTRL:
				begin
					if (avs_writedata[CONFLICT_BIT] && wmask[CONFLICT_BIT])
					begin
						next_s.conflict = 1'b0;
					end
				end
				default:     next_s.conflict = s.conflict;                         // unmapped writes ignored
			endcase
		end

		// external pins: two-stage synchroniser, then edge detect on the second stage
		next_s.extSync1 = extIrqPins;
		next_s.extSync2 = s.extSync1;
		next_s.extPrev = s.extSync2;
		for (int i = 0; i < NUM_EXT; i++)
		begin
			if (i < NUM_POL && s.ctrl[CTRL_EP_LSB + i])
			begin
				extEdge[i] = !s.extSync2[i] && s.extPrev[i];
			end
			else
			begin
				extEdge[i] = s.extSync2[i] && !s.extPrev[i];
			end
		end
		evtVec = {periphEvents[NUM_SRC-1:NUM_EXT], extEdge};

		// events wait in the hold register and land in the flags at cycle start;
		// the set comes after the software clear above, so it wins
		if (coreCtl.cycleStart)
		begin
			next_s.flags = next_s.flags | s.eventHold | evtVec;
			next_s.eventHold = '0;
		end
		else
		begin
			next_s.eventHold = s.eventHold | evtVec;
		end

		// trap conditions
		newTraps = 8'h0;
		newTraps[TRAP_MATH] = trapSrc.divZero
			|| (trapSrc.accOv31[0] && !trapSrc.guardUsed && s.ctrl[CTRL_OVA_BIT])
			|| (trapSrc.accOv31[1] && !trapSrc.guardUsed && s.ctrl[CTRL_OVB_BIT])
			|| ((|trapSrc.accOv39) && trapSrc.satOff && s.ctrl[CTRL_COV_BIT])
			|| trapSrc.shiftTooBig;
		newTraps[TRAP_ADDR] = trapSrc.misaligned || trapSrc.unimplData
			|| trapSrc.unimplProg || trapSrc.vectorFetch
			|| trapSrc.macXinY || trapSrc.macYinX
			|| trapSrc.branchUnimpl || trapSrc.pcUnimpl;
		newTraps[TRAP_STACK] = trapSrc.spLoad
			&& (trapSrc.spValue > s.stackLimit || trapSrc.spValue < STACK_FLOOR);
		newTraps[TRAP_OSC] = trapSrc.oscFail;
		next_s.out.divAbort = trapSrc.divZero;

		// conflict: a hard trap arrives under a higher one pending or in service
		hardAll = s.hardBusy | newTraps[7:4];
		conflict = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (newTraps[4+i] && ((hardAll >> (i + 1)) != 4'h0))
			begin
				conflict = 1'b1;
			end
		end

		// candidate selection from the registered pending sets
		anyTrap = 1'b0;
		trapIdx = 3'h0;
		for (int t = 0; t < 8; t++)
		begin
			if (s.trapPend[t])
			begin
				anyTrap = 1'b1;
				trapIdx = 3'(t);
			end
		end
		pendIrq = s.flags & s.enables;
		anyIrq = 1'b0;
		bestPrio = 3'h0;
		bestSrc = 5'h0;
		// downward scan with >= lets the lowest index win a tie
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pendIrq[i] && (!anyIrq || s.prio[i] >= bestPrio))
			begin
				anyIrq = 1'b1;
				bestPrio = s.prio[i];
				bestSrc = 5'(i);
			end
		end
		candLvl = anyTrap ? {1'b1, trapIdx} : {1'b0, bestPrio};
		vecNum = anyTrap ? {3'h0, trapIdx} : (IRQ_VEC_BASE + 6'(bestSrc));
		qualify = (anyTrap || anyIrq) && (candLvl > s.out.cpuPriorityLevel);

		// take, offer or return
		if (s.out.irqReq && coreCtl.takeAck)
		begin
			if (s.ctxCnt < 4'(CTX_DEPTH))
			begin
				next_s.ctxPc[s.ctxCnt[2:0]] = coreCtl.pc;
				next_s.ctxLvl[s.ctxCnt[2:0]] = s.out.cpuPriorityLevel;
				next_s.ctxSvc[s.ctxCnt[2:0]] = s.out.reqLevel;
				next_s.ctxCnt = s.ctxCnt + 4'h1;
			end
			next_s.out.cpuPriorityLevel = s.out.reqLevel;
			next_s.out.trapPriorityBit = s.out.reqLevel[3];
			if (s.out.reqLevel[3])
			begin
				next_s.trapPend[s.out.reqLevel[2:0]] = 1'b0;
			end
			next_s.out.irqReq = 1'b0;
		end
		else if (coreCtl.returnOp && s.ctxCnt != 4'h0)
		begin
			next_s.out.restoredPc = s.ctxPc[topIdx];
			next_s.out.cpuPriorityLevel = s.ctxLvl[topIdx];
			next_s.out.trapPriorityBit = s.ctxLvl[topIdx][3];
			next_s.out.restoreValid = 1'b1;
			next_s.ctxCnt = s.ctxCnt - 4'h1;
			if (s.ctxSvc[topIdx][3:2] == 2'b11)
			begin
				next_s.hardBusy[s.ctxSvc[topIdx][1:0]] = 1'b0;
			end
		end
		else if (coreCtl.cycleStart)
		begin
			// offers only at an instruction boundary, so the offender completes
			next_s.out.irqReq = qualify;
			next_s.out.reqLevel = candLvl;
			next_s.out.vectorAddr = VECTOR_BASE + 24'({vecNum, 1'b0})
				+ (s.ctrl[CTRL_ALT_BIT] ? ALT_TABLE_OFFSET : 24'h0);
			next_s.out.wake = coreCtl.lowPower && qualify;
		end

		// new traps land after the take clear so none is lost
		next_s.trapPend = next_s.trapPend | newTraps;
		next_s.hardBusy = next_s.hardBusy | newTraps[7:4];
		next_s.out.haltExec = |next_s.trapPend[7:4];

		if (conflict)
		begin
			next_s = reset_state();
			next_s.conflict = 1'b1;
			next_s.out.resetOut = 1'b1;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			s <= reset_state();
		end
		else
		begin
			s <= next_s;
		end
	end

	assign avs_readdata = s.readData;
	assign avs_waitrequest = s.waitReq;
	assign coreOut = s.out;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	property p_trap_bit;
		s.out.trapPriorityBit == s.out.cpuPriorityLevel[3];
	endproperty
	a_trap_bit: assert property (p_trap_bit) else $error("trap bit disagrees with cpu level");

	property p_level7_blocks;
		(s.out.irqReq && s.out.cpuPriorityLevel == 4'h7 && !$past(coreCtl.returnOp)) |-> s.out.reqLevel[3];
	endproperty
	a_level7_blocks: assert property (p_level7_blocks) else $error("interrupt offered at level 7");

	property p_div_abort;
		trapSrc.divZero && !conflict |=> s.out.divAbort && s.trapPend[TRAP_MATH];
	endproperty
	a_div_abort: assert property (p_div_abort) else $error("divide by zero not trapped");

	property p_stack_floor;
		(trapSrc.spLoad && trapSrc.spValue < STACK_FLOOR) |=> (s.trapPend[TRAP_STACK] || s.out.resetOut);
	endproperty
	a_stack_floor: assert property (p_stack_floor) else $error("stack underflow not trapped");

	property p_halt;
		(s.trapPend[7:4] != 4'h0) |-> s.out.haltExec;
	endproperty
	a_halt: assert property (p_halt) else $error("hard trap pending without halt");

	property p_conflict;
		conflict |=> s.out.resetOut && s.conflict && !s.out.irqReq ##1 !s.out.resetOut;
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict did not reset");

	property p_take_level;
		(s.out.irqReq && coreCtl.takeAck && !conflict) |=> s.out.cpuPriorityLevel == $past(s.out.reqLevel);
	endproperty
	a_take_level: assert property (p_take_level) else $error("level not raised on take");

	property p_return;
		(coreCtl.returnOp && s.ctxCnt != 4'h0 && !(s.out.irqReq && coreCtl.takeAck) && !conflict)
			|=> s.out.restoreValid && s.out.cpuPriorityLevel == $past(s.ctxLvl[topIdx]);
	endproperty
	a_return: assert property (p_return) else $error("return did not restore level");

	property p_flags_hold;
		!(busWr && avs_address == OFF_FLAG) && !conflict |=> (s.flags & $past(s.flags)) == $past(s.flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag dropped without clear");

	property p_wake;
		(coreCtl.cycleStart && coreCtl.lowPower && qualify && !coreCtl.takeAck && !coreCtl.returnOp && !conflict)
			|=> s.out.wake && s.out.irqReq;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake for qualifying request");

	c_irq_taken: cover property (s.out.irqReq && !s.out.reqLevel[3] && coreCtl.takeAck);
	c_trap_taken: cover property (s.out.irqReq && s.out.reqLevel[3] && coreCtl.takeAck);
	c_conflict: cover property (s.out.resetOut);
	c_return: cover property (s.out.restoreValid ##[1:20] s.out.irqReq);
endmodule

// ### tb/tisq_pipe_model.sv
`timescale 1ns/1ps
// stand-in for the core pipeline: paces cycles, takes offers, returns
module tisq_pipe_model
	import tisq_pkg::*;
(
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   reset_n,
	// bench commands
	input  wire logic   slowAck,
	input  wire logic   doReturn,
	input  wire logic   doSleep,
	// sequencer side
	input  wire logic   irqReq,
	output tisq_ctl_type coreCtl
);
	logic [1:0] phase;   // four clocks per instruction cycle
	logic [2:0] ackWait; // stall count when slow

	// a slow core lets the offer stand eight clocks, which tests that it holds
	always_ff @(posedge core_clk)
	begin
		coreCtl.takeAck <= 1'b0;
		coreCtl.returnOp <= doReturn;
		coreCtl.pc <= 24'h00a5a4;
		coreCtl.lowPower <= doSleep;
		phase <= phase + 2'h1;
		coreCtl.cycleStart <= (phase == 2'h3);
		if (!reset_n)
		begin
			phase <= 2'h0;
			ackWait <= 3'h0;
			coreCtl <= '0;
		end
		else if (irqReq && !coreCtl.takeAck)
		begin
			// the stall count restarts with every take, so each slow offer waits the same
			ackWait <= (!slowAck || ackWait == 3'h7) ? 3'h0 : ackWait + 3'h1;
			coreCtl.takeAck <= !slowAck || (ackWait == 3'h7);
		end
	end
endmodule

// ### tb/test_trap_and_interrupt_sequencer.sv
`timescale 1ns/1ps
module test_trap_and_interrupt_sequencer
	import tisq_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
	} tisq_row_type;
	// register rows: address, write, data, read-back expectation
	tisq_row_type rows [9] = '{'{OFF_STATUS, 1'b0, 32'h0, 32'h0},
		'{OFF_PRIO_HI, 1'b0, 32'h0, 32'h44444444}, '{OFF_STKLIM, 1'b0, 32'h0, 32'hffff},
		'{OFF_RSTCTRL, 1'b0, 32'h0, 32'h0}, '{8'h3c, 1'b1, 32'hffffffff, 32'h0},
		'{OFF_STATUS, 1'b1, 32'hf, 32'h7}, '{OFF_STATUS, 1'b1, 32'h0, 32'h0},
		'{OFF_PRIO_LO, 1'b1, 32'h500000, 32'h500000}, '{OFF_ENABLE, 1'b1, 32'h20, 32'h20}};
	logic             core_clk = 1'b0;
	logic             reset_n  = 1'b0;
	logic [7:0]       addr     = 8'h0;
	logic             rd       = 1'b0;
	logic             wr       = 1'b0;
	logic [31:0]      wdata    = 32'h0;
	logic [31:0]      rdata;
	logic             wreq;
	tisq_ctl_type     coreCtl;
	tisq_trapsrc_type trap     = '0;
	logic [15:0]      ev       = 16'h0;
	tisq_out_type     coreOut;
	logic             slowAck  = 1'b0;
	logic             doReturn = 1'b0;
	logic             doSleep  = 1'b0;
	logic [4:0]       extPins  = 5'h0;
	int               errTotal = 0;
	int               checks   = 0;
	logic [31:0]      q;

	always #10 core_clk = ~core_clk;

	tisq_core tisq_core_inst (.core_clk(core_clk), .reset_n(reset_n), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .coreCtl(coreCtl), .trapSrc(trap),
		.periphEvents(ev), .extIrqPins(extPins), .coreOut(coreOut));
	tisq_pipe_model tisq_pipe_model_inst (.core_clk(core_clk), .reset_n(reset_n), .slowAck(slowAck),
		.doReturn(doReturn), .doSleep(doSleep), .irqReq(coreOut.irqReq), .coreCtl(coreCtl));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		while (wreq !== 1'b0)
			@(posedge core_clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge core_clk);
	endtask

	// bounded wait for offer, restore or internal reset
	task automatic waitOut(input int sel);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 60 && hit !== 1'b1; i++)
		begin
			@(posedge core_clk);
			hit = (sel == 0) ? coreOut.irqReq : (sel == 1) ? coreOut.restoreValid : coreOut.resetOut;
		end
		check(32'(hit), 32'h1, "handshake");
	endtask

	task automatic pulseReturn;
		doReturn <= 1'b1;
		@(posedge core_clk);
		doReturn <= 1'b0;
		waitOut(1);
		check(32'(coreOut.restoredPc), 32'h00a5a4, "restored pc");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog sized well above the few hundred cycles of the tests
	initial
	begin
		repeat (5000) @(posedge core_clk);
		errTotal++;
		end_sim;
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			check(q, rows[i].e, "register");
		end
		$display("register test done");
		// source 5 at priority 5 against level 0
		ev <= 16'h0020;
		@(posedge core_clk);
		ev <= 16'h0;
		waitOut(0);
		check(32'(coreOut.reqLevel), 32'h5, "level");
		check(32'(coreOut.vectorAddr), 32'h1e, "vector");
		repeat (8) @(posedge core_clk);
		check(32'(coreOut.cpuPriorityLevel), 32'h5, "cpu level");
		check(32'(coreOut.irqReq), 32'h0, "offer at equal level");
		pulseReturn;
		// flag still set, so it offers again once the level drops
		waitOut(0);
		bus(1'b1, OFF_FLAG, 32'h20);
		pulseReturn;
		repeat (2) @(posedge core_clk);
		check(32'(coreOut.cpuPriorityLevel), 32'h0, "level after return");
		$display("interrupt test done");
		// level 7 masks the request but a stack trap still gets through
		bus(1'b1, OFF_STATUS, 32'h7);
		ev <= 16'h0020;
		@(posedge core_clk);
		ev <= 16'h0;
		repeat (12) @(posedge core_clk);
		check(32'(coreOut.irqReq), 32'h0, "masked offer");
		bus(1'b1, OFF_CTRL, 32'h8000);
		slowAck <= 1'b1;
		trap.spLoad <= 1'b1;
		trap.spValue <= 16'h07ff;
		@(posedge core_clk);
		trap <= '0;
		waitOut(0);
		check(32'(coreOut.reqLevel), 32'hd, "trap level");
		check(32'(coreOut.vectorAddr), 32'h8e, "alt vector");
		// the slow core has not taken the hard trap yet, so execution stays halted
		check(32'(coreOut.haltExec), 32'h1, "halt");
		repeat (12) @(posedge core_clk);
		check(32'(coreOut.cpuPriorityLevel), 32'hd, "trap cpu level");
		check(32'(coreOut.trapPriorityBit), 32'h1, "trap bit");
		check(32'(coreOut.haltExec), 32'h0, "halt after take");
		// lower hard trap while the stack trap is in service
		trap.misaligned <= 1'b1;
		@(posedge core_clk);
		trap <= '0;
		waitOut(2);
		bus(1'b0, OFF_RSTCTRL, 32'h0);
		check(q, 32'h8000, "conflict flag");
		$display("trap test done");
		// an external reset in mid-run clears the conflict flag again
		reset_n <= 1'b0;
		slowAck <= 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		bus(1'b0, OFF_RSTCTRL, 32'h0);
		check(q, 32'h0, "conflict flag after reset");
		$display("reset test done");
		// pin 0 set to falling edges: its rising edge must not request
		bus(1'b1, OFF_CTRL, 32'h1);
		bus(1'b1, OFF_ENABLE, 32'h1);
		extPins <= 5'h1;
		repeat (16) @(posedge core_clk);
		check(32'(coreOut.irqReq), 32'h0, "rising edge ignored");
		// core asleep; the falling edge requests at level 4 and wakes it
		doSleep <= 1'b1;
		extPins <= 5'h0;
		waitOut(0);
		check(32'(coreOut.wake), 32'h1, "wake");
		check(32'(coreOut.vectorAddr), 32'h14, "pin vector");
		// divide by zero while the pin handler runs
		trap.divZero <= 1'b1;
		@(posedge core_clk);
		trap <= '0;
		@(posedge core_clk);
		check(32'(coreOut.divAbort), 32'h1, "divide abort");
		waitOut(0);
		check(32'(coreOut.reqLevel), 32'hb, "math trap level");
		check(32'(coreOut.vectorAddr), 32'ha, "math vector");
		check(32'(coreOut.haltExec), 32'h0, "soft trap runs on");
		$display("pin and math test done");
		end_sim;
	end
endmodule
